// [common/step_timer_cfg.svh]
/*
 * Constants for the stepper compare-match timer: register offsets, field
 * positions, reset values and timing counts.
 * Assumes it is included by bare name from the package and the design file.
 */
`ifndef STEP_TIMER_CFG_SVH
`define STEP_TIMER_CFG_SVH

// Register offsets (byte addresses on the plain port)
`define ADDR_TIMER_MODE       16'hff80
`define ADDR_TIMER_CONTROL    16'hff81
`define ADDR_TIMER_IRQ_ENABLE 16'hff82
`define ADDR_TIMER_FLAGS      16'hff83
`define ADDR_TIMER_IO_CONTROL 16'hff84
`define ADDR_COUNTER_HI       16'hff86
`define ADDR_COUNTER_LO       16'hff87
`define ADDR_COMPARE_HI       16'hff88
`define ADDR_COMPARE_LO       16'hff89
`define ADDR_PORT_DATA        16'hffd8
`define ADDR_PORT_DIRECTION   16'hffe8
`define ADDR_IRQ_STATUS       16'hff8a
`define ADDR_IRQ_MASK         16'hff8b

// Field positions
`define BIT_COUNT_START       7
`define BIT_CLEAR_ON_MATCH    7
`define BIT_CLOCK_SELECT_HI   6
`define BIT_CLOCK_SELECT_LO   4
`define BIT_MATCH_A_IRQ_EN    0
`define BIT_MATCH_A_FLAG      0
`define BIT_CAPTURE_SELECT    2
`define BIT_PIN_ACTION_HI     1
`define BIT_PIN_ACTION_LO     0

// Clock select encodings
`define CKS_DIV1              3'h0
`define CKS_DIV2              3'h1
`define CKS_DIV4              3'h2
`define CKS_DIV8              3'h3

// Reset values
`define RST_REG8              8'h00
`define RST_REG16             16'h0000
`define RST_COMPARE           16'hffff
`define IRQ_STATUS_BITS       2

// Timing: documented system clock and prescale, ours runs at 20 MHz
`define SYS_CLK_MHZ           20
`define DOC_SYS_CLK_MHZ       16
`define DOC_PRESCALE          4
`define PRESCALE_WIDTH        3

`endif

// [common/step_timer_pkg.sv]
/*
 * Types for the stepper compare-match timer.
 * Assumes the configuration header sits beside it on the include path.
 */
package step_timer_pkg;
`include "step_timer_cfg.svh"

    // One register access from the plain port
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // Counter input source
    typedef enum logic [1:0] {
        SRC_DIV1,
        SRC_DIV2,
        SRC_DIV4,
        SRC_DIV8
    } clk_src_t;

endpackage : step_timer_pkg

// [verilog/stepper_compare_match_timer.sv]
/*
 * Sixteen-bit compare-match timer with a four-line phase output port for a
 * two-phase stepper. Holds the register file, prescaler, counter, compare,
 * flags, interrupt and port.
 * Assumes a single 20 MHz clock, a master that never overlaps strobes, and
 * software that reloads compare and port pattern in the interrupt handler.
 */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "step_timer_cfg.svh"

module stepper_compare_match_timer
    import step_timer_pkg::*;
(
    input  wire logic        ref_clk,    // 20 MHz system clock
    input  wire logic        rst_b,      // Synchronous reset, active low
    input  wire logic [15:0] regAddr,    // Register byte address
    input  wire logic [7:0]  regWdata,   // Write data
    input  wire logic        regWr,      // Write strobe
    input  wire logic        regRd,      // Read strobe
    output logic      [7:0]  regRdata,   // Read data, cycle after strobe
    output logic             irq,        // Level interrupt
    output logic      [7:0]  portOut,    // Port pin output values
    output logic      [7:0]  portOe,     // Port pin output enables
    output logic      [3:0]  phaseLines  // Phase-excitation lines
);

    // Register map, bytes:
    //   ff80 mode
    //   ff81 control
    //   ff82 match enable
    //   ff83 match flag
    //   ff84 io control
    //   ff86 counter high
    //   ff87 counter low
    //   ff88 compare high
    //   ff89 compare low
    //   ff8a sticky events
    //   ff8b event mask
    //   ffd8 port data
    //   ffe8 port direction
    // Unmapped places read zero.
    // Resets: all zero but the
    // compare, which is ffff.
    //
    // Step time at div4 with
    // clear-on-match is compare
    // plus one ticks of four
    // clocks each.
    //
    // Flag clear: read it as one,
    // then write zero to ff83.
    // A match in the clear cycle
    // wins and keeps it set.
    //
    // Events clear by writing one
    // to the bit in ff8a.
    //
    // Phase lines show data and
    // direction ANDed bit by bit.
    //
    // In capture role the compare
    // follows the counter on every
    // tick and no match is made.
    //
    // Pin action 00 is all that is
    // modelled: no pin on a match.
    //
    // Writes never stall: there is
    // no wait state on this port.

    // Bus request as one struct
    reg_req_t req;
    assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    // Software-visible registers

    // Mode: bit 7 runs the counter
    // Other bits are stored only
    logic [7:0]  timerMode;

    // Control: bit 7 clear-on-match
    // Bits 6 to 4 pick the rate
    logic [7:0]  timerControl;

    // Enable: bit 0 gates the flag onto irq
    logic [7:0]  timerIrqEnable;

    // Io control: bit 2 capture
    // Bits 1 and 0 stored only
    logic [7:0]  timerIoControl;

    // Counter, byte-written
    logic [15:0] upCounter;

    // Compare, or captured count
    logic [15:0] stepPeriodCompare;

    // Port data register
    // Low nibble feeds the phases
    logic [7:0]  phasePortData;

    // Port direction, one is out
    logic [7:0]  phasePortDirection;

    // Sticky match flag
    logic        matchAFlag;

    // Sticky events: match, wrap
    logic [`IRQ_STATUS_BITS-1:0] irqStatus;

    // Mask of the sticky events
    logic [`IRQ_STATUS_BITS-1:0] irqMask;

    // Flag was read as one
    // since the last write of zero to the flag
    logic        flagSeenSet;

    // Divider behind the ticks
    logic [`PRESCALE_WIDTH-1:0]  prescaler;

    // High compare byte on hold
    logic [7:0]  compareLowHold;

    // Exact decode, no aliasing

    // Address decode, used by the write paths; the read path decodes in its own case
    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic clk_src_t decodeSource(input logic [2:0] cks);
        case (cks)
            `CKS_DIV1: decodeSource = SRC_DIV1;
            `CKS_DIV2: decodeSource = SRC_DIV2;
            `CKS_DIV4: decodeSource = SRC_DIV4;
            default:   decodeSource = SRC_DIV8;
        endcase
    endfunction : decodeSource

    // Counter runs while set
    logic     countStart;

    // Counter drops to zero on match
    logic     clearOnMatch;

    // Compare captures instead
    // of comparing
    logic     captureMode;

    // Stored, never acted on
    logic [1:0] pinAction;

    // Chosen count rate
    clk_src_t source;

    // One-cycle enable at that rate
    logic     countTick;

    // Counter equals compare
    logic     compareEqual;

    // Match, taken on a tick only
    // so it fires once per pass
    logic     matchEvent;

    // Software writes a counter byte
    // and wins over counting
    logic     counterWrite;

    // Write of zero to the flag
    logic     flagWriteZero;

    assign countStart   = timerMode[`BIT_COUNT_START];
    assign clearOnMatch = timerControl[`BIT_CLEAR_ON_MATCH];
    assign source       = decodeSource(
        timerControl[`BIT_CLOCK_SELECT_HI:`BIT_CLOCK_SELECT_LO]);
    assign captureMode  = timerIoControl[`BIT_CAPTURE_SELECT];
    assign pinAction    = timerIoControl[`BIT_PIN_ACTION_HI:`BIT_PIN_ACTION_LO];

    // The divider never stops, so
    // the first tick after a start
    // may come up to seven early at div8, three at div4.

    // Free-running prescaler; a tick is a one-cycle enable at the chosen rate.
    // At div4 a count lasts four system clocks, so the match period is
    // compare value plus one, times four clocks, when clear-on-match is set.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            prescaler <= '0;
        end else begin
            prescaler <= prescaler + 3'h1;
        end
    end

    // One divider for all rates
    // keeps them in phase.

    // Tick selection from the prescaler
    always_comb begin
        case (source)
            SRC_DIV1: countTick = 1'b1;
            SRC_DIV2: countTick = (prescaler[0] == 1'b1);
            SRC_DIV4: countTick = (prescaler[1:0] == 2'h3);
            default:  countTick = (prescaler == 3'h7);
        endcase
    end

    // Compare zero with clear-on-
    // match fires every tick.

    // Match is a compare of the live counter against the compare register,
    // taken on the tick that would step past it so each match fires once.
    assign compareEqual = (upCounter == stepPeriodCompare);
    assign matchEvent   = countStart && countTick && compareEqual && !captureMode;
    assign counterWrite = req.wr && (hit(req.addr, `ADDR_COUNTER_HI) ||
                                     hit(req.addr, `ADDR_COUNTER_LO));

    // Byte writes land at once, so
    // stop the counter before a
    // write to avoid a torn value.

    // Counter: software write wins, otherwise advance while started
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            upCounter <= `RST_REG16;
        end else if (req.wr && hit(req.addr, `ADDR_COUNTER_HI)) begin
            upCounter <= {req.wdata, upCounter[7:0]};
        end else if (req.wr && hit(req.addr, `ADDR_COUNTER_LO)) begin
            upCounter <= {upCounter[15:8], req.wdata};
        end else if (countStart && countTick) begin
            if (matchEvent && clearOnMatch) begin
                upCounter <= `RST_REG16;
            end else begin
                upCounter <= upCounter + 16'h0001;
            end
        end
    end

    // A lone low write reuses the
    // last held high byte.

    // Compare register; in capture mode it snapshots the counter instead.
    // High byte is buffered until the low byte lands so a half-written
    // period never produces a stray match.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            stepPeriodCompare <= `RST_COMPARE;
            compareLowHold    <= `RST_REG8;
        end else if (req.wr && hit(req.addr, `ADDR_COMPARE_HI)) begin
            compareLowHold <= req.wdata;
        end else if (req.wr && hit(req.addr, `ADDR_COMPARE_LO)) begin
            stepPeriodCompare <= {compareLowHold, req.wdata};
        end else if (captureMode && countStart && countTick) begin
            stepPeriodCompare <= upCounter;
        end
    end

    // Unmapped writes fall through
    // and change nothing.

    // Plain control registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            timerMode          <= `RST_REG8;
            timerControl       <= `RST_REG8;
            timerIrqEnable     <= `RST_REG8;
            timerIoControl     <= `RST_REG8;
            phasePortData      <= `RST_REG8;
            phasePortDirection <= `RST_REG8;
            irqMask            <= '0;
        end else if (req.wr) begin
            if (hit(req.addr, `ADDR_TIMER_MODE))       timerMode          <= req.wdata;
            if (hit(req.addr, `ADDR_TIMER_CONTROL))    timerControl       <= req.wdata;
            if (hit(req.addr, `ADDR_TIMER_IRQ_ENABLE)) timerIrqEnable     <= req.wdata;
            if (hit(req.addr, `ADDR_TIMER_IO_CONTROL)) timerIoControl     <= req.wdata;
            if (hit(req.addr, `ADDR_PORT_DATA))        phasePortData      <= req.wdata;
            if (hit(req.addr, `ADDR_PORT_DIRECTION))   phasePortDirection <= req.wdata;
            if (hit(req.addr, `ADDR_IRQ_MASK))         irqMask <= req.wdata[`IRQ_STATUS_BITS-1:0];
        end
    end

    // A blind write of zero cannot
    // drop a match not yet seen;
    // a write of one does nothing.

    // Match flag: clear by writing 0 after reading it as 1; a new match in
    // the same cycle as the clear keeps the flag set.
    assign flagWriteZero = req.wr && hit(req.addr, `ADDR_TIMER_FLAGS) &&
                           !req.wdata[`BIT_MATCH_A_FLAG];
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            matchAFlag  <= 1'b0;
            flagSeenSet <= 1'b0;
        end else begin
            if (matchEvent) begin
                matchAFlag <= 1'b1;
            end else if (flagWriteZero && flagSeenSet) begin
                matchAFlag <= 1'b0;
            end
            if (req.rd && hit(req.addr, `ADDR_TIMER_FLAGS) && matchAFlag) begin
                flagSeenSet <= 1'b1;
            end else if (flagWriteZero) begin
                flagSeenSet <= 1'b0;
            end
        end
    end

    // A second, mask-gated path
    // to the interrupt.

    // Sticky event status: bit 0 match, bit 1 counter wrap; write 1 clears,
    // set wins over a clear in the same cycle.
    logic [`IRQ_STATUS_BITS-1:0] events;
    assign events = {countStart && countTick && (upCounter == 16'hffff) && !counterWrite,
                     matchEvent};
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irqStatus <= '0;
        end else begin
            irqStatus <= events | (irqStatus &
                ~((req.wr && hit(req.addr, `ADDR_IRQ_STATUS)) ?
                  req.wdata[`IRQ_STATUS_BITS-1:0] : {`IRQ_STATUS_BITS{1'b0}}));
        end
    end

    // Combinational: drops in the
    // cycle the flag clears.

    // Interrupt: the match request follows the flag, so clearing the flag
    // drops it; the sticky status adds the masked event sources.
    assign irq = (matchAFlag && timerIrqEnable[`BIT_MATCH_A_IRQ_EN]) ||
                 |(irqStatus & irqMask);

    // Direction gates only the
    // phase lines, not the pins.

    // Port pins: the data register drives every output line; the compare
    // match never touches a pin since only pin action 00 is supported.
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gPort
            assign portOut[g] = phasePortData[g];
            assign portOe[g]  = phasePortDirection[g];
        end
    endgenerate
    assign phaseLines = phasePortData[3:0] & phasePortDirection[3:0];

    // Reads only arm the flag
    // clear; data fall back to
    // zero so none is stale.

    // Read data, registered, valid the cycle after the strobe only
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            regRdata <= `RST_REG8;
        end else if (!req.rd) begin
            regRdata <= `RST_REG8;
        end else begin
            case (req.addr)
                `ADDR_TIMER_MODE:       regRdata <= timerMode;
                `ADDR_TIMER_CONTROL:    regRdata <= timerControl;
                `ADDR_TIMER_IRQ_ENABLE: regRdata <= timerIrqEnable;
                `ADDR_TIMER_FLAGS:      regRdata <= {7'h00, matchAFlag};
                `ADDR_TIMER_IO_CONTROL: regRdata <= timerIoControl;
                `ADDR_COUNTER_HI:       regRdata <= upCounter[15:8];
                `ADDR_COUNTER_LO:       regRdata <= upCounter[7:0];
                `ADDR_COMPARE_HI:       regRdata <= stepPeriodCompare[15:8];
                `ADDR_COMPARE_LO:       regRdata <= stepPeriodCompare[7:0];
                `ADDR_PORT_DATA:        regRdata <= phasePortData;
                `ADDR_PORT_DIRECTION:   regRdata <= phasePortDirection;
                `ADDR_IRQ_STATUS:       regRdata <= {6'h00, irqStatus};
                `ADDR_IRQ_MASK:         regRdata <= {6'h00, irqMask};
                default:                regRdata <= `RST_REG8;
            endcase
        end
    end

    // Pin action is stored only;
    // this fold marks it as read.

    logic unusedPinAction;
    assign unusedPinAction = ^pinAction;

endmodule : stepper_compare_match_timer
`default_nettype wire

// [test/stepper_compare_match_timer_props.sv]
/* Assertions on the stepper timer's ports.
   Assumes it is bound to the top module and sees nothing inside it. */
`timescale 1ns/1ns
`default_nettype none
`include "step_timer_cfg.svh"
module stepper_compare_match_timer_props (
    input wire logic        ref_clk,   // Clock
    input wire logic        rst_b,     // Reset
    input wire logic [15:0] regAddr,   // Address
    input wire logic [7:0]  regWdata,  // Write data
    input wire logic        regWr,     // Write strobe
    input wire logic        regRd,     // Read strobe
    input wire logic [7:0]  regRdata,  // Read data
    input wire logic        irq,       // Interrupt
    input wire logic [7:0]  portOut,   // Port values
    input wire logic [7:0]  portOe,    // Port enables
    input wire logic [3:0]  phaseLines // Phase lines
);
    logic enOn;     // Shadow of the match enable
    logic maskOn;   // Shadow of any mask bit
    logic flagRd;   // Flag register read last cycle
    logic flagSeen; // Flag read as set, not written since
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // Shadows follow writes, so the irq gate is judged from the ports alone
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            enOn <= 1'b0;
            maskOn <= 1'b0;
            flagRd <= 1'b0;
            flagSeen <= 1'b0;
        end else begin
            if (regWr && regAddr == `ADDR_TIMER_IRQ_ENABLE) enOn <= regWdata[0];
            if (regWr && regAddr == `ADDR_IRQ_MASK) maskOn <= |regWdata[1:0];
            flagRd <= regRd && regAddr == `ADDR_TIMER_FLAGS;
            if (regWr && regAddr == `ADDR_TIMER_FLAGS) flagSeen <= 1'b0;
            else if (flagRd && regRdata[0]) flagSeen <= 1'b1;
        end
    end
    property p_rd_idle; !$past(regRd) |-> regRdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_flag_hold; flagRd && flagSeen |-> regRdata[0]; endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
    property p_phase; phaseLines == (portOut[3:0] & portOe[3:0]); endproperty
    a_phase: assert property (p_phase) else $error("phase lines wrong");
    property p_data; regWr && regAddr == `ADDR_PORT_DATA |=> portOut == $past(regWdata); endproperty
    a_data: assert property (p_data) else $error("port data not taken");
    property p_dir; regWr && regAddr == `ADDR_PORT_DIRECTION |=> portOe == $past(regWdata); endproperty
    a_dir: assert property (p_dir) else $error("direction not taken");
    property p_pins;
        $past(rst_b) && portOut != $past(portOut) |->
            $past(regWr) && $past(regAddr) == `ADDR_PORT_DATA;
    endproperty
    a_pins: assert property (p_pins) else $error("pins moved without write");
    property p_oe;
        $past(rst_b) && portOe != $past(portOe) |->
            $past(regWr) && $past(regAddr) == `ADDR_PORT_DIRECTION;
    endproperty
    a_oe: assert property (p_oe) else $error("enables moved without write");
    property p_irq_gate; !enOn && !maskOn |-> !irq; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while gated");
endmodule : stepper_compare_match_timer_props
bind stepper_compare_match_timer stepper_compare_match_timer_props u_props (
    .ref_clk, .rst_b, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .irq, .portOut, .portOe, .phaseLines
);
`default_nettype wire

// [test/step_motor_model.sv]
/* Motor driver model: tracks rotor position from the phase lines.
   Assumes the lines are sampled on the system clock. */
`timescale 1ns/1ns
`default_nettype none
module step_motor_model (
    input  wire logic       ref_clk,  // System clock
    input  wire logic [3:0] phases,   // Phase-excitation lines
    output int              position, // Half steps, forward positive
    output int              badMoves  // Changes that skip a half step
);
    int         ring[8] = '{8, 12, 4, 6, 2, 3, 1, 9}; // Half-step ring
    logic [3:0] last    = 4'h0;
    int         pos     = 0;
    int         bad     = 0;
    function automatic int slot(input logic [3:0] p);
        for (int i = 0; i < 8; i++) if (ring[i] == p) return i;
        return 99;
    endfunction : slot
    // One half step per change; any other change would lose torque
    always @(posedge ref_clk) begin
        if (phases !== last && last != 4'h0) begin
            if (slot(phases) == (slot(last) + 1) % 8) pos++;
            else if (slot(phases) == (slot(last) + 7) % 8) pos--;
            else bad++;
        end
        last <= phases;
    end
    assign position = pos;
    assign badMoves = bad;
endmodule : step_motor_model
`default_nettype wire

// [test/stepper_compare_match_timer_bench.sv]
/* Self-checking bench for the stepper timer with a motor model.
   Assumes package, header, checker and motor model compile first. */
`timescale 1ns/1ns
`default_nettype none
`include "step_timer_cfg.svh"
module stepper_compare_match_timer_bench;
    logic        ref_clk, rst_b, regWr, regRd, irq;
    logic [15:0] regAddr;
    logic [7:0]  regWdata, regRdata, portOut, portOe, rv, a, b;
    logic [3:0]  phaseLines;
    int          errors, n_compared, position, badMoves, pos, idx, n, t, tPrev, k, cs;
    int          cyc     = 0;
    int          expQ[$];      // Expected match periods in cycles
    int          pat[8]  = '{8'h08, 8'h0c, 8'h04, 8'h06, 8'h02, 8'h03, 8'h01, 8'h09};
    logic [15:0] regs[14] = '{16'hff80, 16'hff81, 16'hff82, 16'hff83, 16'hff84, 16'hff86,
        16'hff87, 16'hff88, 16'hff89, 16'hffd8, 16'hffe8, 16'hff8a, 16'hff8b, 16'hff85};
    stepper_compare_match_timer u_stepper_compare_match_timer (.ref_clk, .rst_b, .regAddr,
        .regWdata, .regWr, .regRd, .regRdata, .irq, .portOut, .portOe, .phaseLines);
    step_motor_model u_step_motor_model (.ref_clk, .phases(phaseLines), .position, .badMoves);
    // 20 MHz clock and a cycle count for period checks
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // Bus tasks leave a quiet cycle so no strobe is assigned twice at one edge
    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        regAddr <= ad;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [15:0] ad, output logic [7:0] d);
        regAddr <= ad;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
        @(posedge ref_clk);
    endtask : rd
    task automatic wait_irq;
        int i;
        for (i = 0; i < 3000; i++) begin
            @(negedge ref_clk);
            if (irq === 1'b1) break;
        end
        t = cyc;
        if (irq !== 1'b1) begin
            errors++;
            $display("mismatch at %0t: no irq", $time);
            test_done();
        end
        @(posedge ref_clk);
    endtask : wait_irq
    // Two reads forty cycles apart of a counting register
    task automatic cnt_diff(input logic [15:0] ad, input int exp);
        rd(ad, a);
        repeat (38) @(posedge ref_clk);
        rd(ad, b);
        chk(8'(b - a), 16'(exp));
    endtask : cnt_diff
    initial begin
        rst_b = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 16'h0000;
        regWdata = 8'h00;
        errors = 0;
        n_compared = 0;
        pos = 0;
        idx = 0;
        void'($urandom(32'h2246));
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        // Reset values; compare resets high, the unmapped place reads zero
        foreach (regs[i]) begin
            rd(regs[i], rv);
            chk(rv, (regs[i] inside {16'hff88, 16'hff89}) ? 8'hff : 8'h00);
        end
        // Data reaches the phase lines only once they are outputs
        repeat (4) begin
            rv = 8'($urandom);
            wr(`ADDR_PORT_DATA, rv);
            chk({portOut, 4'h0, phaseLines}, {rv, 8'h00});
        end
        wr(`ADDR_PORT_DATA, 8'h08);
        wr(`ADDR_PORT_DIRECTION, 8'h0f);
        chk({portOe, 4'h0, phaseLines}, 16'h0f08);
        // Paced stepping with a shortened period table, forward then back
        n = 8 + $urandom % 8;
        wr(`ADDR_COUNTER_LO, 8'h00);
        wr(`ADDR_COMPARE_LO, 8'(n));
        wr(`ADDR_TIMER_CONTROL, 8'ha0);
        wr(`ADDR_TIMER_IRQ_ENABLE, 8'h01);
        wr(`ADDR_TIMER_MODE, 8'h80);
        for (k = 0; k < 10; k++) begin
            wait_irq();
            if (k > 0) chk(16'(t - tPrev), 16'(expQ.pop_front()));
            tPrev = t;
            chk(16'(position), 16'(pos));
            if (k == 0) wr(`ADDR_TIMER_FLAGS, 8'h00);
            chk(irq, 1'b1);
            rd(`ADDR_TIMER_FLAGS, rv);
            chk(rv[0], 1'b1);
            wr(`ADDR_TIMER_FLAGS, 8'h00);
            chk(irq, 1'b0);
            n = 8 + $urandom % 8;
            expQ.push_back((n + 1) * 4);
            wr(`ADDR_COMPARE_LO, 8'(n));
            idx = (k < 5) ? (idx + 1) % 8 : (idx + 7) % 8;
            pos += (k < 5) ? 1 : -1;
            wr(`ADDR_PORT_DATA, 8'(pat[idx]));
        end
        // Stopped counter holds; free counting runs through a low compare
        wr(`ADDR_TIMER_MODE, 8'h00);
        cnt_diff(`ADDR_COUNTER_LO, 0);
        wr(`ADDR_TIMER_IRQ_ENABLE, 8'h00);
        wr(`ADDR_COUNTER_LO, 8'h00);
        wr(`ADDR_COMPARE_LO, 8'h03);
        wr(`ADDR_TIMER_MODE, 8'h80);
        for (cs = 3; cs >= 0; cs--) begin
            wr(`ADDR_TIMER_CONTROL, 8'(cs << 4));
            cnt_diff(`ADDR_COUNTER_LO, 40 >> cs);
        end
        chk(irq, 1'b0);
        rd(`ADDR_TIMER_FLAGS, rv);
        chk(rv[0], 1'b1);
        // Status and mask pair: raise, then clear by writing one
        wr(`ADDR_IRQ_MASK, 8'h01);
        chk(irq, 1'b1);
        wr(`ADDR_IRQ_STATUS, 8'h01);
        chk(irq, 1'b0);
        rd(`ADDR_TIMER_FLAGS, rv);
        chk(rv[0], 1'b1);
        wr(`ADDR_TIMER_FLAGS, 8'h00);
        // Capture role tracks the counter and raises no match
        wr(`ADDR_TIMER_IO_CONTROL, 8'h04);
        wr(`ADDR_TIMER_CONTROL, 8'h20);
        cnt_diff(`ADDR_COMPARE_LO, 10);
        rd(`ADDR_TIMER_FLAGS, rv);
        chk(rv[0], 1'b0);
        chk(16'(badMoves), 16'h0000);
        test_done();
    end
endmodule : stepper_compare_match_timer_bench
`default_nettype wire
